// >>> core/amc_mode_control.sv
// Acquisition mode control with AXI4-Lite register bank and standby sequencer
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module amc_mode_control #(
   parameter int ADDR_W    = 8,
   parameter int MS_CYCLES = amc_pkg::MS_CYCLES
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire amc_pkg::amc_meas_t  meas,
   input  wire logic                chopper_clk_src,
   output logic                     chopper_clock_out,
   output logic                     mode_change_indicator,
   output logic                     acq_active,
   output logic                     stopped,
   output logic                     irq
);

   localparam int MS_W  = $clog2(MS_CYCLES + 1);
   localparam int SEC_W = $clog2(amc_pkg::MS_PER_S + 1);

   generate
      if (MS_CYCLES < 1 || ADDR_W < 7 || ADDR_W > 32) begin : g_bad_param
         $error("amc_mode_control: unsupported parameter value");
      end
   endgenerate

   function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
      logic [31:0] wide;
      wide = 32'h0000_0000;
      wide[ADDR_W-1:0] = addr;
      return wide[9:2];
   endfunction

   function automatic logic idx_mapped(input logic [7:0] idx);
      return (idx >= amc_pkg::IDX_MODE_CTL && idx <= amc_pkg::IDX_THRESHOLD_LOW) ||
             (idx >= amc_pkg::IDX_IRQ_STATUS && idx <= amc_pkg::IDX_BLOCK_STATE);
   endfunction

   // Register bank
   amc_pkg::amc_mode_ctl_t      mode_ctl_reg;
   logic [7:0]                  interval_high_reg;
   logic [7:0]                  interval_low_reg;
   logic [7:0]                  threshold_high_reg;
   logic [7:0]                  threshold_low_reg;
   logic [amc_pkg::IRQ_W-1:0]   irq_status_reg;
   logic [amc_pkg::IRQ_W-1:0]   irq_mask_reg;

   // Bus slave state
   logic                        awready_reg;
   logic                        wready_reg;
   logic                        bvalid_reg;
   logic [1:0]                  bresp_reg;
   logic                        arready_reg;
   logic                        rvalid_reg;
   logic [31:0]                 rdata_reg;
   logic [1:0]                  rresp_reg;
   logic                        aw_held_reg;
   logic                        w_held_reg;
   logic [7:0]                  aw_idx_reg;
   logic [7:0]                  w_data_reg;
   logic                        w_lane0_reg;

   // Sequencer state
   amc_pkg::amc_state_t         state_reg;
   logic [3:0]                  discard_reg;
   logic [MS_W-1:0]             ms_cnt_reg;
   logic [SEC_W-1:0]            sec_cnt_reg;
   logic [14:0]                 interval_reg;
   logic                        indicator_reg;
   logic                        chop_reg;
   logic                        acq_reg;
   logic                        stopped_reg;
   logic                        irq_reg;

   logic                        aw_hs;
   logic                        w_hs;
   logic                        b_hs;
   logic                        ar_hs;
   logic                        r_hs;
   logic                        do_write;
   logic                        wr_en;
   logic                        mode_written;
   logic                        abort;
   logic                        standby_sel;
   logic                        crossing;
   logic                        ms_tick;
   logic                        unit_tick;
   logic                        interval_done;
   logic                        ev_release;
   logic                        ev_wake;
   logic                        ev_sample;
   logic [amc_pkg::IRQ_W-1:0]   irq_set;
   logic [amc_pkg::IRQ_W-1:0]   irq_clr;
   logic [15:0]                 threshold;
   logic [7:0]                  rd_idx;
   logic [7:0]                  rd_val;

   assign aw_hs    = s_axi_awvalid & awready_reg;
   assign w_hs     = s_axi_wvalid & wready_reg;
   assign b_hs     = bvalid_reg & s_axi_bready;
   assign ar_hs    = s_axi_arvalid & arready_reg;
   assign r_hs     = rvalid_reg & s_axi_rready;
   assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wr_en    = do_write & w_lane0_reg & idx_mapped(aw_idx_reg);
   assign mode_written = wr_en && aw_idx_reg == amc_pkg::IDX_MODE_CTL;
   assign threshold    = {threshold_high_reg, threshold_low_reg};

   // Write address and data are taken independently, answered once both are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b0;
         aw_held_reg <= 1'b0;
         aw_idx_reg  <= 8'h00;
      end else if (aw_hs) begin
         awready_reg <= 1'b0;
         aw_held_reg <= 1'b1;
         aw_idx_reg  <= reg_index(s_axi_awaddr);
      end else if (b_hs) begin
         awready_reg <= 1'b1;
         aw_held_reg <= 1'b0;
      end else if (!aw_held_reg && !bvalid_reg) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_reg  <= 1'b0;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 8'h00;
         w_lane0_reg <= 1'b0;
      end else if (w_hs) begin
         wready_reg  <= 1'b0;
         w_held_reg  <= 1'b1;
         w_data_reg  <= s_axi_wdata[7:0];
         w_lane0_reg <= s_axi_wstrb[0];
      end else if (b_hs) begin
         wready_reg  <= 1'b1;
         w_held_reg  <= 1'b0;
      end else if (!w_held_reg && !bvalid_reg) begin
         wready_reg  <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= amc_pkg::RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= idx_mapped(aw_idx_reg) ? amc_pkg::RESP_OKAY : amc_pkg::RESP_SLVERR;
      end else if (b_hs) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Read path
   assign rd_idx = reg_index(s_axi_araddr);

   always_comb begin
      rd_val = 8'h00;
      unique case (rd_idx)
         amc_pkg::IDX_MODE_CTL:       rd_val = mode_ctl_reg;
         amc_pkg::IDX_INTERVAL_HIGH:  rd_val = interval_high_reg;
         amc_pkg::IDX_INTERVAL_LOW:   rd_val = interval_low_reg;
         amc_pkg::IDX_THRESHOLD_HIGH: rd_val = threshold_high_reg;
         amc_pkg::IDX_THRESHOLD_LOW:  rd_val = threshold_low_reg;
         amc_pkg::IDX_IRQ_STATUS:     rd_val = {5'h00, irq_status_reg};
         amc_pkg::IDX_IRQ_MASK:       rd_val = {5'h00, irq_mask_reg};
         amc_pkg::IDX_BLOCK_STATE:    rd_val = {5'h00, state_reg};
         default:                     rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= amc_pkg::RESP_OKAY;
      end else if (ar_hs) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= {24'h00_0000, rd_val};
         rresp_reg   <= idx_mapped(rd_idx) ? amc_pkg::RESP_OKAY : amc_pkg::RESP_SLVERR;
      end else if (r_hs) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
      end else if (!rvalid_reg) begin
         arready_reg <= 1'b1;
      end
   end

   // Configuration registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_ctl_reg       <= amc_pkg::MODE_CTL_RST;
         interval_high_reg  <= amc_pkg::INTERVAL_HIGH_RST;
         interval_low_reg   <= amc_pkg::INTERVAL_LOW_RST;
         threshold_high_reg <= amc_pkg::THRESHOLD_HIGH_RST;
         threshold_low_reg  <= amc_pkg::THRESHOLD_LOW_RST;
         irq_mask_reg       <= amc_pkg::IRQ_MASK_RST;
      end else if (wr_en) begin
         unique case (aw_idx_reg)
            amc_pkg::IDX_MODE_CTL:       mode_ctl_reg       <= w_data_reg;
            amc_pkg::IDX_INTERVAL_HIGH:  interval_high_reg  <= w_data_reg;
            amc_pkg::IDX_INTERVAL_LOW:   interval_low_reg   <= w_data_reg;
            amc_pkg::IDX_THRESHOLD_HIGH: threshold_high_reg <= w_data_reg;
            amc_pkg::IDX_THRESHOLD_LOW:  threshold_low_reg  <= w_data_reg;
            amc_pkg::IDX_IRQ_MASK:       irq_mask_reg       <= w_data_reg[amc_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Sticky event flags, write one to clear, a new event wins over the clear
   assign irq_set = {ev_sample, ev_wake, ev_release};
   assign irq_clr = (wr_en && aw_idx_reg == amc_pkg::IDX_IRQ_STATUS) ?
                    w_data_reg[amc_pkg::IRQ_W-1:0] : 3'h0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status_reg <= 3'h0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
      end
   end

   // Sequencer
   assign abort       = mode_written | ~mode_ctl_reg.release_run;
   assign standby_sel = mode_ctl_reg.mode == amc_pkg::MODE_STANDBY_ONE ||
                        mode_ctl_reg.mode == amc_pkg::MODE_STANDBY_TWO;
   assign crossing    = meas.current >= threshold;
   assign ev_release  = state_reg == amc_pkg::ST_STOP && !abort;
   assign ev_wake     = state_reg == amc_pkg::ST_COMPARE && !abort && meas.valid &&
                        mode_ctl_reg.mode == amc_pkg::MODE_STANDBY_TWO && crossing;
   assign ev_sample   = state_reg == amc_pkg::ST_COMPARE && !abort && meas.valid &&
                        mode_ctl_reg.mode == amc_pkg::MODE_STANDBY_ONE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg   <= amc_pkg::ST_STOP;
         discard_reg <= 4'h0;
      end else if (abort) begin
         state_reg   <= amc_pkg::ST_STOP;
      end else begin
         unique case (state_reg)
            amc_pkg::ST_STOP: begin
               state_reg <= standby_sel ? amc_pkg::ST_WAIT : amc_pkg::ST_NORMAL;
            end
            amc_pkg::ST_NORMAL: begin
               state_reg <= amc_pkg::ST_NORMAL;
            end
            amc_pkg::ST_WAIT: begin
               if (interval_done) begin
                  state_reg   <= amc_pkg::ST_DISCARD;
                  discard_reg <= 4'(mode_ctl_reg.skip) + 4'(amc_pkg::SKIP_BASE);
               end
            end
            amc_pkg::ST_DISCARD: begin
               if (meas.valid) begin
                  if (discard_reg == 4'h1) begin
                     state_reg <= amc_pkg::ST_COMPARE;
                  end
                  discard_reg <= discard_reg - 4'h1;
               end
            end
            amc_pkg::ST_COMPARE: begin
               if (ev_wake) begin
                  state_reg <= amc_pkg::ST_NORMAL;
               end else if (meas.valid) begin
                  state_reg <= amc_pkg::ST_WAIT;
               end
            end
         endcase
      end
   end

   // Standby interval timer, runs only while waiting
   assign ms_tick       = ms_cnt_reg == MS_W'(MS_CYCLES - 1);
   assign unit_tick     = interval_high_reg[amc_pkg::UNIT_BIT] ?
                          (ms_tick && sec_cnt_reg == SEC_W'(amc_pkg::MS_PER_S - 1)) :
                          ms_tick;
   assign interval_done = interval_reg == 15'h0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_cnt_reg   <= '0;
         sec_cnt_reg  <= '0;
         interval_reg <= 15'h0000;
      end else if (state_reg != amc_pkg::ST_WAIT) begin
         ms_cnt_reg   <= '0;
         sec_cnt_reg  <= '0;
         interval_reg <= {interval_high_reg[6:0], interval_low_reg};
      end else begin
         ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + MS_W'(1);
         if (ms_tick) begin
            sec_cnt_reg <= (sec_cnt_reg == SEC_W'(amc_pkg::MS_PER_S - 1)) ?
                           '0 : sec_cnt_reg + SEC_W'(1);
         end
         if (unit_tick && !interval_done) begin
            interval_reg <= interval_reg - 15'h0001;
         end
      end
   end

   // Pin outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         indicator_reg <= 1'b0;
      end else if (ev_wake && mode_ctl_reg.ind_en) begin
         indicator_reg <= 1'b1;
      end else if (mode_written || !mode_ctl_reg.ind_en) begin
         indicator_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chop_reg <= 1'b0;
      end else begin
         chop_reg <= chopper_clk_src & mode_ctl_reg.chop_en;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acq_reg     <= 1'b0;
         stopped_reg <= 1'b1;
         irq_reg     <= 1'b0;
      end else begin
         acq_reg     <= state_reg == amc_pkg::ST_NORMAL || state_reg == amc_pkg::ST_DISCARD ||
                        state_reg == amc_pkg::ST_COMPARE;
         stopped_reg <= state_reg == amc_pkg::ST_STOP;
         irq_reg     <= |(irq_status_reg & irq_mask_reg);
      end
   end

   assign s_axi_awready         = awready_reg;
   assign s_axi_wready          = wready_reg;
   assign s_axi_bvalid          = bvalid_reg;
   assign s_axi_bresp           = bresp_reg;
   assign s_axi_arready         = arready_reg;
   assign s_axi_rvalid          = rvalid_reg;
   assign s_axi_rdata           = rdata_reg;
   assign s_axi_rresp           = rresp_reg;
   assign chopper_clock_out     = chop_reg;
   assign mode_change_indicator = indicator_reg;
   assign acq_active            = acq_reg;
   assign stopped               = stopped_reg;
   assign irq                   = irq_reg;

endmodule

// >>> core/amc_pkg.sv
// Shared constants, register map and types of the acquisition mode control block
package amc_pkg;

   // Timing
   localparam int CLK_HZ        = 50_000_000;
   localparam int MS_TIME_MS    = 1;
   localparam int MS_CYCLES     = CLK_HZ / 1000 * MS_TIME_MS;
   localparam int MS_PER_S      = 1000;
   localparam int SKIP_BASE     = 3;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_MODE_CTL       = 8'h0a;
   localparam logic [7:0] IDX_INTERVAL_HIGH  = 8'h0b;
   localparam logic [7:0] IDX_INTERVAL_LOW   = 8'h0c;
   localparam logic [7:0] IDX_THRESHOLD_HIGH = 8'h0d;
   localparam logic [7:0] IDX_THRESHOLD_LOW  = 8'h0e;
   localparam logic [7:0] IDX_IRQ_STATUS     = 8'h10;
   localparam logic [7:0] IDX_IRQ_MASK       = 8'h11;
   localparam logic [7:0] IDX_BLOCK_STATE    = 8'h12;

   // Reset values
   localparam logic [7:0] MODE_CTL_RST       = 8'h00;
   localparam logic [7:0] INTERVAL_HIGH_RST  = 8'h80;
   localparam logic [7:0] INTERVAL_LOW_RST   = 8'h00;
   localparam logic [7:0] THRESHOLD_HIGH_RST = 8'h00;
   localparam logic [7:0] THRESHOLD_LOW_RST  = 8'h00;
   localparam logic [2:0] IRQ_MASK_RST       = 3'h0;

   // Field positions not covered by a struct
   localparam int UNIT_BIT   = 7;
   localparam int IRQ_RELEASE = 0;
   localparam int IRQ_WAKE    = 1;
   localparam int IRQ_SAMPLE  = 2;
   localparam int IRQ_W       = 3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MODE_NORMAL_ONE    = 2'h0,
      MODE_NORMAL_TWO    = 2'h1,
      MODE_STANDBY_ONE   = 2'h2,
      MODE_STANDBY_TWO   = 2'h3
   } amc_mode_t;

   typedef struct packed {
      amc_mode_t  mode;
      logic [2:0] skip;
      logic       chop_en;
      logic       ind_en;
      logic       release_run;
   } amc_mode_ctl_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] current;
   } amc_meas_t;

   typedef enum logic [2:0] {
      ST_STOP    = 3'h0,
      ST_NORMAL  = 3'h1,
      ST_WAIT    = 3'h3,
      ST_DISCARD = 3'h2,
      ST_COMPARE = 3'h6
   } amc_state_t;

endpackage

// >>> tb/amc_mode_control_sva.sv
// Assertion checker of the acquisition mode control block
`timescale 1ns/1ps
module amc_mode_control_sva #(
   parameter int ADDR_W = 8
) (
   input wire logic              aclk,
   input wire logic              aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic [31:0]       s_axi_wdata,
   input wire logic [3:0]        s_axi_wstrb,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic              s_axi_bvalid,
   input wire logic              chopper_clk_src,
   input wire logic              chopper_clock_out,
   input wire logic              mode_change_indicator,
   input wire logic              acq_active,
   input wire logic              stopped
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic [ADDR_W-1:0] wa;
   logic [7:0]        wd, mode_m;
   logic              ws, bv_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_m <= 8'h00;
         bv_q   <= 1'b0;
      end else begin
         bv_q <= s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) begin
            wd <= s_axi_wdata[7:0];
            ws <= s_axi_wstrb[0];
         end
         if (s_axi_bvalid && !bv_q && ws && wa == ADDR_W'(8'h28)) mode_m <= wd;
      end
   end
   chk_chop_copy: assert property (
      chopper_clock_out |-> $past(chopper_clk_src))
      else $error("chopper output high without source");
   chk_chop_off: assert property (
      (!mode_m[2]) [*2] |-> !chopper_clock_out)
      else $error("chopper output while disabled");
   chk_stop_hold: assert property (
      (!mode_m[0]) [*3] |-> stopped)
      else $error("left stop without release");
   chk_ind_off: assert property (
      (!mode_m[1]) [*2] |-> !mode_change_indicator)
      else $error("indicator while disabled");
   chk_ind_source: assert property (
      $rose(mode_change_indicator) |-> mode_m[7:6] == 2'h3 && mode_m[1])
      else $error("indicator outside standby two");
   chk_wake_run: assert property (
      $rose(mode_change_indicator) |-> acq_active && !stopped)
      else $error("indicator without acquisition");
   chk_run_excl: assert property (
      !(stopped && acq_active))
      else $error("stopped and active together");
   chk_leave_stop: assert property (
      $fell(stopped) |-> mode_m[0])
      else $error("stop left with release clear");
   chk_mode_entry: assert property (
      $fell(stopped) |-> acq_active == !mode_m[7])
      else $error("wrong mode entered on release");
   cover property ($rose(mode_change_indicator));
   cover property ($fell(stopped) && mode_m[7]);
   cover property (chopper_clock_out);
endmodule

bind amc_mode_control amc_mode_control_sva #(.ADDR_W(ADDR_W)) u_sva (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .chopper_clk_src(chopper_clk_src), .chopper_clock_out(chopper_clock_out),
   .mode_change_indicator(mode_change_indicator), .acq_active(acq_active),
   .stopped(stopped)
);

// >>> tb/amc_host_model.sv
// Host model: AXI4-Lite master that programs the register bank
`timescale 1ns/1ps
module amc_host_model (
   input  wire logic        aclk,
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial {awvalid, wvalid, bready, arvalid, rready, awaddr, wdata, wstrb, araddr} = '0;
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic s,
                     output logic [1:0] resp, output logic ok);
      ok = 1'b0;
      @(posedge aclk);
      awaddr  <= {idx[5:0], 2'b00};
      wdata   <= {24'h0, d};
      wstrb   <= {3'h0, s};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 100 && !ok; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            ok = 1'b1;
         end
      end
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                     output logic [1:0] resp, output logic ok);
      ok = 1'b0;
      @(posedge aclk);
      araddr  <= {idx[5:0], 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 100 && !ok; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            ok = 1'b1;
         end
      end
   endtask
endmodule

// >>> tb/test_acquisition_mode_control.sv
// Self-checking testbench of the acquisition mode control block
`timescale 1ns/1ps
module test_acquisition_mode_control;
   logic               aclk, aresetn, chop_src, chop_out, ind, acq, stp, irq, ok;
   logic               awvalid, awready, wvalid, wready, bvalid, bready;
   logic               arvalid, arready, rvalid, rready;
   logic [7:0]         awaddr, araddr;
   logic [31:0]        wdata, rdata, rv;
   logic [3:0]         wstrb;
   logic [1:0]         bresp, rresp, rs;
   amc_pkg::amc_meas_t meas;
   int                 num_errors = 0;
   int                 cmp_count = 0;
   amc_mode_control #(.ADDR_W(8), .MS_CYCLES(4)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .meas(meas),
      .chopper_clk_src(chop_src), .chopper_clock_out(chop_out),
      .mode_change_indicator(ind), .acq_active(acq), .stopped(stp), .irq(irq));
   amc_host_model host (
      .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   initial aclk = 1'b0;
   always #10 aclk = ~aclk;
   always @(posedge aclk) chop_src <= ~chop_src;
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic hang(input string what);
      $display("ERROR %s expected progress seen timeout", what);
      num_errors++;
      print_verdict();
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wreg(input logic [7:0] idx, d, input logic s = 1'b1, input logic [1:0] er = 2'h0);
      host.wr(idx, d, s, rs, ok);
      if (!ok) hang("write");
      check("bresp", 32'(er), 32'(rs));
   endtask
   task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp,
                       input logic [1:0] er);
      host.rd(idx, rv, rs, ok);
      if (!ok) hang(what);
      check(what, exp, rv);
      check(what, {30'h0, er}, {30'h0, rs});
   endtask
   task automatic wait_run();
      tick(3);
      for (int n = 0; n < 20 && stp; n++) @(posedge aclk);
      if (stp) hang("leave stop");
   endtask
   task automatic pulse(input logic [15:0] cur);
      @(posedge aclk);
      meas <= '{valid: 1'b1, current: cur};
      @(posedge aclk);
      meas.valid <= 1'b0;
      tick(3);
   endtask
   task automatic t_reset();
      check("stopped", 32'h1, {31'h0, stp});
      rchk("mode_control", 8'h0a, 32'h0, 2'h0);
      rchk("interval_high", 8'h0b, 32'h80, 2'h0);
      rchk("interval_low", 8'h0c, 32'h0, 2'h0);
      rchk("threshold_high", 8'h0d, 32'h0, 2'h0);
      rchk("threshold_low", 8'h0e, 32'h0, 2'h0);
      rchk("unmapped", 8'h0f, 32'h0, amc_pkg::RESP_SLVERR);
      wreg(8'h0f, 8'h55, 1'b1, 2'h2);
      $display("test reset done");
   endtask
   task automatic t_regs();
      logic [7:0] v [4] = '{8'h7f, 8'hff, 8'h01, 8'h80};
      for (int i = 0; i < 4; i++) begin
         wreg(8'h0b + 8'(i), v[i]);
         rchk("reg rw", 8'h0b + 8'(i), {24'h0, v[i]}, 2'h0);
      end
      wreg(8'h0d, 8'h33, 1'b0);
      rchk("strobe off", 8'h0d, {24'h0, v[2]}, 2'h0);
      $display("test registers done");
   endtask
   task automatic t_normal();
      for (int m = 0; m < 2; m++) begin
         wreg(8'h0a, {2'(m), 6'h01});
         wait_run();
         check("normal active", 32'h1, {31'h0, acq});
         rchk("normal state", 8'h12, 32'h1, 2'h0);
         wreg(8'h0a, {2'(m), 6'h00});
         tick(4);
         check("held stop", 32'h1, {31'h0, stp});
      end
      $display("test normal done");
   endtask
   task automatic t_chop();
      logic p;
      wreg(8'h0a, 8'h04);
      tick(2);
      for (int i = 0; i < 6; i++) begin
         p = chop_src;
         @(posedge aclk);
         check("chopper copy", {31'h0, p}, {31'h0, chop_out});
      end
      wreg(8'h0a, 8'h00);
      tick(2);
      for (int i = 0; i < 6; i++) begin
         @(posedge aclk);
         check("chopper off", 32'h0, {31'h0, chop_out});
      end
      $display("test chopper done");
   endtask
   task automatic t_wait(input logic [7:0] hi, input logic [7:0] lo, input int exp);
      int n = 0;
      wreg(8'h0a, 8'h00);
      wreg(8'h0b, hi);
      wreg(8'h0c, lo);
      wreg(8'h0a, 8'h81);
      for (int i = 0; i < 5000 && !acq; i++) begin
         @(posedge aclk);
         if (!stp && !acq) n++;
      end
      if (!acq) hang("interval");
      cmp_count++;
      if (n < exp || n > exp + 2) begin
         $display("ERROR wait cycles expected %0d seen %0d", exp, n);
         num_errors++;
      end
      $display("test interval done");
   endtask
   task automatic t_standby();
      logic [2:0] sk;
      wreg(8'h0b, 8'h00);
      wreg(8'h0c, 8'h00);
      wreg(8'h0d, 8'h12);
      wreg(8'h0e, 8'h34);
      wreg(8'h11, 8'h02);
      for (int k = 0; k < 2; k++) begin
         sk = k ? 3'h7 : 3'h0;
         wreg(8'h0a, {2'h3, sk, 1'b0, !k[0], 1'b1});
         wait_run();
         repeat (3 + sk) pulse(16'hffff);
         rchk("discards done", 8'h12, 32'h6, 2'h0);
         pulse(16'h1233);
         rchk("below threshold", 8'h12, 32'h2, 2'h0);
         repeat (3 + sk) pulse(16'hffff);
         pulse(16'h1234);
         rchk("wake state", 8'h12, 32'h1, 2'h0);
         check("indicator", {31'h0, !k[0]}, {31'h0, ind});
      end
      check("irq wake", 32'h1, {31'h0, irq});
      wreg(8'h11, 8'h00);
      tick(2);
      check("irq masked", 32'h0, {31'h0, irq});
      wreg(8'h11, 8'h02);
      wreg(8'h10, 8'h02);
      tick(2);
      check("irq cleared", 32'h0, {31'h0, irq});
      rchk("irq status", 8'h10, 32'h1, 2'h0);
      $display("test standby done");
   endtask
   initial begin
      {aresetn, chop_src} = 2'b00;
      meas = '0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      tick(2);
      t_reset();
      t_regs();
      t_normal();
      t_chop();
      t_wait(8'h01, 8'h02, 1032);
      t_wait(8'h80, 8'h01, 4000);
      t_standby();
      print_verdict();
   end
endmodule
